//--- rtl/scsi_inquiry_responder.sv
// INQUIRY command interpreter with AHB-Lite register access.
// Assumes din_ready comes from logic on hclk; text memory loaded by software.
// What this block does
// - Opcode 12h; byte1 bit1 command support, bit0 vital page; page byte2, length byte4.
// - Neither selector and page zero returns standard identification data.
// - Vital-page selector alone with supported page returns that page.
// - Command-support selector alone with supported code returns support data.
// - Illegal selector/page combinations end with CHECK CONDITION, invalid field.
// - Allocation length zero sends no response bytes.
// - Send the smaller of available bytes and allocation length.
// - Pending unit attention does not block the command and stays pending.
// - Other commands except request sense to an absent unit get CHECK CONDITION.
// - Byte 0 zero, or qualifier 011b with type 1Fh when unit absent.
// - Byte 1 zero; byte 2 compliance fields zero, version 3.
// - Byte 3 format two, task termination and normal ACA zero.
// - Byte 4 additional length 159; byte 5 zero.
// - Byte 6 holds only the 16-bit address flag.
// - Medium changer flag zero since removable media is zero.
// - Byte 7: sync, linked, queuing set; wide16 follows support; others zero.
// - Soft reset flag reads zero.
// - Byte 53 clocking 11b, quick arbitration and information unit zero.
// - ASCII identity fields at their positions; reserved bytes zero.
// - Support field 001b unsupported, 011b supported in conformance.
// - Supported pages list 80h and 83h ascending, page length 02h.
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
module scsi_inquiry_responder (
	input wire logic hclk, // Clock, 40 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write flag
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic [31:0] hrdata, // Read data
	output logic hresp, // Response, always OKAY
	output logic [7:0] din_byte, // Response byte to initiator
	output logic din_valid, // Response byte valid
	input wire logic din_ready, // Initiator takes byte
	output logic status_valid, // Status byte pulse
	output logic [7:0] status_byte // Command status
);
	typedef struct packed {
		inquiry_pkg::state_t st;
		inquiry_pkg::kind_t kind;
		logic [5:0][7:0] cdb;
		logic lun_absent;
		logic wide16;
		logic ua_pending;
		logic busy;
		logic done;
		logic check;
		logic [3:0] sense_key;
		logic [7:0] asc;
		logic [7:0] idx;
		logic [7:0] limit;
		logic [7:0] sent;
		logic ap_wr;
		logic [4:0] ap_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic [7:0] din_byte;
		logic din_valid;
		logic status_valid;
		logic [7:0] status_byte;
	} regs_t;

	regs_t r_r, r_nxt;
	text_mem_if tm ();

	text_mem u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.port(tm.mem)
	);

	logic [7:0] op, page, alloc;
	logic cs, vp, accept;
	assign op = r_r.cdb[0];
	assign cs = r_r.cdb[1][inquiry_pkg::CDB_CMDSUP_BIT];
	assign vp = r_r.cdb[1][inquiry_pkg::CDB_VPD_BIT];
	assign page = r_r.cdb[2];
	assign alloc = r_r.cdb[4];
	assign accept = hsel && htrans[1] && hready;

	assign tm.we = r_r.ap_wr && (r_r.ap_addr == inquiry_pkg::OFS_TEXT);
	assign tm.waddr = hwdata[7:0];
	assign tm.wdata = hwdata[15:8];
	assign tm.raddr = (r_r.kind == inquiry_pkg::K_VPD80) ? 8'(r_r.idx + inquiry_pkg::SERIAL_RAM_BASE) : r_r.idx;

	// Response byte at index i; text positions come from the memory
	function automatic logic [7:0] resp_byte(inquiry_pkg::kind_t k, logic [7:0] i, logic absent,
		logic w16, logic [7:0] pg, logic [7:0] txt);
		logic [7:0] b;
		b = 8'h00;
		if (i == 8'h00) begin
			b = absent ? inquiry_pkg::QUAL_ABSENT : 8'h00;
		end else begin
			case (k)
				inquiry_pkg::K_STD: begin
					case (i)
						8'h02: b = inquiry_pkg::STD_VERSION;
						8'h03: b = inquiry_pkg::STD_FORMAT;
						8'h04: b = inquiry_pkg::STD_ADDL_LEN;
						8'h06: b = inquiry_pkg::STD_FLAGS6;
						8'h07: begin
							b = inquiry_pkg::STD_FLAGS7;
							b[inquiry_pkg::FLAG7_WB16] = w16;
						end
						8'h35: b = inquiry_pkg::STD_CLOCKING;
						default: begin
							if ((i >= 8'h08 && i <= 8'h2B) || (i >= 8'h60 && i <= 8'h91)) begin
								b = txt;
							end
						end
					endcase
				end
				inquiry_pkg::K_VPD00: begin
					case (i)
						8'h03: b = inquiry_pkg::VPD00_LEN;
						8'h04: b = inquiry_pkg::PAGE_SERIAL;
						8'h05: b = inquiry_pkg::PAGE_DEVID;
						default: b = 8'h00;
					endcase
				end
				inquiry_pkg::K_VPD80: begin
					case (i)
						8'h01: b = inquiry_pkg::PAGE_SERIAL;
						8'h03: b = inquiry_pkg::VPD80_LEN;
						default: b = (i >= 8'h04) ? txt : 8'h00;
					endcase
				end
				inquiry_pkg::K_VPD83: b = (i == 8'h01) ? inquiry_pkg::PAGE_DEVID : 8'h00;
				inquiry_pkg::K_CMD: begin
					case (i)
						8'h01: b = {5'h00, (pg == inquiry_pkg::OP_INQUIRY) ? inquiry_pkg::SUP_STD
							: inquiry_pkg::SUP_NONE};
						8'h02: b = inquiry_pkg::STD_VERSION;
						8'h05: b = (pg == inquiry_pkg::OP_INQUIRY) ? inquiry_pkg::CDB6_SIZE : 8'h00;
						8'h06: b = inquiry_pkg::OP_INQUIRY;
						8'h07: b = inquiry_pkg::USE_SEL;
						8'h08: b = inquiry_pkg::USE_FULL;
						8'h0A: b = inquiry_pkg::USE_FULL;
						8'h0B: b = inquiry_pkg::USE_SEL;
						default: b = 8'h00;
					endcase
				end
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	always_comb begin
		logic [7:0] avail;
		logic err;
		avail = 8'h00;
		err = 1'b0;
		r_nxt = r_r;
		r_nxt.status_valid = 1'b0;
		r_nxt.hreadyout = 1'b1;
		// Bus data phase: apply a pending write
		if (r_r.ap_wr) begin
			case (r_r.ap_addr)
				inquiry_pkg::OFS_CDB_LO: begin
					if (!r_r.busy) begin
						r_nxt.cdb[3:0] = hwdata;
					end
				end
				inquiry_pkg::OFS_CDB_HI: begin
					if (!r_r.busy) begin
						r_nxt.cdb[5:4] = hwdata[15:0];
					end
				end
				inquiry_pkg::OFS_CTRL: begin
					r_nxt.lun_absent = hwdata[inquiry_pkg::CTRL_LUN_ABSENT];
					r_nxt.wide16 = hwdata[inquiry_pkg::CTRL_WIDE16];
					r_nxt.ua_pending = hwdata[inquiry_pkg::CTRL_UA];
					if (hwdata[inquiry_pkg::CTRL_START] && !r_r.busy) begin
						r_nxt.st = inquiry_pkg::S_DECODE;
						r_nxt.busy = 1'b1;
						r_nxt.done = 1'b0;
						r_nxt.check = 1'b0;
						r_nxt.sense_key = 4'h0;
						r_nxt.asc = 8'h00;
						r_nxt.sent = 8'h00;
						r_nxt.idx = 8'h00;
					end
				end
				default: ;
			endcase
		end
		// Bus address phase: latch, and prepare read data
		r_nxt.ap_wr = accept && hwrite;
		r_nxt.ap_addr = haddr[4:0];
		if (accept && !hwrite) begin
			case (haddr[4:0])
				inquiry_pkg::OFS_CDB_LO: r_nxt.hrdata = r_r.cdb[3:0];
				inquiry_pkg::OFS_CDB_HI: r_nxt.hrdata = {16'h0000, r_r.cdb[5:4]};
				inquiry_pkg::OFS_CTRL: r_nxt.hrdata = {28'h0000000, r_r.ua_pending, r_r.wide16,
					r_r.lun_absent, 1'b0};
				inquiry_pkg::OFS_STATUS: r_nxt.hrdata = {r_r.sent, r_r.asc, 4'h0, r_r.sense_key,
					5'h00, r_r.check, r_r.done, r_r.busy};
				default: r_nxt.hrdata = 32'h00000000;
			endcase
		end
		case (r_r.st)
			inquiry_pkg::S_IDLE: ;
			inquiry_pkg::S_DECODE: begin
				// Unit attention is neither checked nor cleared here
				r_nxt.st = inquiry_pkg::S_STATUS;
				if (op != inquiry_pkg::OP_INQUIRY) begin
					if (r_r.lun_absent && op != inquiry_pkg::OP_REQ_SENSE) begin
						r_nxt.check = 1'b1;
						r_nxt.sense_key = inquiry_pkg::SK_ILLEGAL;
						r_nxt.asc = inquiry_pkg::ASC_BAD_LUN;
					end
				end else begin
					if (cs && vp) begin
						err = 1'b1;
					end else if (vp) begin
						case (page)
							inquiry_pkg::PAGE_SUPPORTED: begin
								r_nxt.kind = inquiry_pkg::K_VPD00;
								avail = inquiry_pkg::LEN_VPD00;
							end
							inquiry_pkg::PAGE_SERIAL: begin
								r_nxt.kind = inquiry_pkg::K_VPD80;
								avail = inquiry_pkg::LEN_VPD80;
							end
							inquiry_pkg::PAGE_DEVID: begin
								r_nxt.kind = inquiry_pkg::K_VPD83;
								avail = inquiry_pkg::LEN_VPD83;
							end
							default: err = 1'b1;
						endcase
					end else if (cs) begin
						if (page >= inquiry_pkg::PAGE_VENDOR_BASE) begin
							err = 1'b1;
						end else begin
							r_nxt.kind = inquiry_pkg::K_CMD;
							avail = (page == inquiry_pkg::OP_INQUIRY) ? inquiry_pkg::LEN_CMD_OK
								: inquiry_pkg::LEN_CMD_NO;
						end
					end else if (page != 8'h00) begin
						err = 1'b1;
					end else begin
						r_nxt.kind = inquiry_pkg::K_STD;
						avail = inquiry_pkg::LEN_STD;
					end
					if (err) begin
						r_nxt.check = 1'b1;
						r_nxt.sense_key = inquiry_pkg::SK_ILLEGAL;
						r_nxt.asc = inquiry_pkg::ASC_BAD_FIELD;
					end else begin
						r_nxt.limit = (alloc < avail) ? alloc : avail;
						if (alloc != 8'h00) begin
							r_nxt.st = inquiry_pkg::S_FETCH;
						end
					end
				end
			end
			inquiry_pkg::S_FETCH: r_nxt.st = inquiry_pkg::S_LOAD;
			inquiry_pkg::S_LOAD: begin
				r_nxt.din_byte = resp_byte(r_r.kind, r_r.idx, r_r.lun_absent, r_r.wide16, page, tm.rdata);
				r_nxt.din_valid = 1'b1;
				r_nxt.st = inquiry_pkg::S_HOLD;
			end
			inquiry_pkg::S_HOLD: begin
				if (din_ready) begin
					r_nxt.din_valid = 1'b0;
					r_nxt.idx = 8'(r_r.idx + 8'h01);
					r_nxt.sent = 8'(r_r.sent + 8'h01);
					r_nxt.st = (8'(r_r.idx + 8'h01) == r_r.limit) ? inquiry_pkg::S_STATUS
						: inquiry_pkg::S_FETCH;
				end
			end
			inquiry_pkg::S_STATUS: begin
				r_nxt.status_valid = 1'b1;
				r_nxt.status_byte = r_r.check ? inquiry_pkg::ST_CHECK : inquiry_pkg::ST_GOOD;
				r_nxt.busy = 1'b0;
				r_nxt.done = 1'b1;
				r_nxt.st = inquiry_pkg::S_IDLE;
			end
			default: r_nxt.st = inquiry_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_r <= '{st: inquiry_pkg::S_IDLE, kind: inquiry_pkg::K_STD, hreadyout: 1'b1, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign hreadyout = r_r.hreadyout;
	assign hrdata = r_r.hrdata;
	assign hresp = 1'b0;
	assign din_byte = r_r.din_byte;
	assign din_valid = r_r.din_valid;
	assign status_valid = r_r.status_valid;
	assign status_byte = r_r.status_byte;

	logic dec12;
	assign dec12 = (r_r.st == inquiry_pkg::S_DECODE) && (op == inquiry_pkg::OP_INQUIRY) && !r_r.ap_wr;

	chk_foreign_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == inquiry_pkg::S_DECODE && op != inquiry_pkg::OP_INQUIRY) |=> r_r.st == inquiry_pkg::S_STATUS)
		else $error("non-inquiry opcode sent data");
	chk_std_select: assert property (@(posedge hclk) disable iff (!hresetn)
		(dec12 && !cs && !vp && page == 8'h00 && alloc != 8'h00) |=>
		(r_r.kind == inquiry_pkg::K_STD && r_r.st == inquiry_pkg::S_FETCH))
		else $error("standard data not selected");
	chk_vpd_select: assert property (@(posedge hclk) disable iff (!hresetn)
		(dec12 && !cs && vp && page == inquiry_pkg::PAGE_SERIAL) |=> r_r.kind == inquiry_pkg::K_VPD80 && !r_r.check)
		else $error("serial page not selected");
	chk_cmd_select: assert property (@(posedge hclk) disable iff (!hresetn)
		(dec12 && cs && !vp && page < inquiry_pkg::PAGE_VENDOR_BASE) |=> r_r.kind == inquiry_pkg::K_CMD)
		else $error("command support not selected");
	chk_both_reject: assert property (@(posedge hclk) disable iff (!hresetn)
		(dec12 && cs && vp) |=> r_r.check ##1 (status_valid && status_byte == inquiry_pkg::ST_CHECK))
		else $error("both selectors not rejected");
	chk_zero_alloc: assert property (@(posedge hclk) disable iff (!hresetn)
		(dec12 && alloc == 8'h00) |=> !din_valid [*2])
		else $error("bytes sent with zero allocation");
	chk_limit_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == inquiry_pkg::S_FETCH) |-> (r_r.limit <= alloc && r_r.idx < r_r.limit))
		else $error("transfer exceeds allocation");
	chk_lun_check: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == inquiry_pkg::S_DECODE && op != inquiry_pkg::OP_INQUIRY && op != inquiry_pkg::OP_REQ_SENSE
		&& r_r.lun_absent) |=> ##1 (status_byte == inquiry_pkg::ST_CHECK))
		else $error("absent unit not checked");
	chk_absent_byte0: assert property (@(posedge hclk) disable iff (!hresetn)
		(din_valid && r_r.idx == 8'h00 && r_r.lun_absent) |-> din_byte == inquiry_pkg::QUAL_ABSENT)
		else $error("byte 0 wrong for absent unit");
	chk_addl_len: assert property (@(posedge hclk) disable iff (!hresetn)
		(din_valid && r_r.kind == inquiry_pkg::K_STD && r_r.idx == 8'h04) |-> din_byte == inquiry_pkg::STD_ADDL_LEN)
		else $error("additional length wrong");
	chk_byte_order: assert property (@(posedge hclk) disable iff (!hresetn)
		(din_valid && din_ready) |=> (r_r.idx == 8'($past(r_r.idx) + 8'h01)) && !din_valid)
		else $error("bytes out of order");
endmodule

//--- rtl/inquiry_pkg.sv
// Constants for the INQUIRY command responder: register map, CDB layout,
// response byte map and status codes.
// Assumes a single 40 MHz clock domain and an AHB-Lite register port.
package inquiry_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CDB_LO = 5'h00;
	localparam logic [4:0] OFS_CDB_HI = 5'h04;
	localparam logic [4:0] OFS_CTRL = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_TEXT = 5'h10;
	// Control register bits
	localparam int CTRL_START = 0;
	localparam int CTRL_LUN_ABSENT = 1;
	localparam int CTRL_WIDE16 = 2;
	localparam int CTRL_UA = 3;
	// CDB fields
	localparam logic [7:0] OP_INQUIRY = 8'h12;
	localparam logic [7:0] OP_REQ_SENSE = 8'h03;
	localparam int CDB_CMDSUP_BIT = 1;
	localparam int CDB_VPD_BIT = 0;
	localparam logic [7:0] PAGE_VENDOR_BASE = 8'hC0;
	localparam logic [7:0] PAGE_SUPPORTED = 8'h00;
	localparam logic [7:0] PAGE_SERIAL = 8'h80;
	localparam logic [7:0] PAGE_DEVID = 8'h83;
	// Response lengths
	localparam logic [7:0] LEN_STD = 8'hA4;
	localparam logic [7:0] LEN_VPD00 = 8'h06;
	localparam logic [7:0] LEN_VPD80 = 8'h14;
	localparam logic [7:0] LEN_VPD83 = 8'h04;
	localparam logic [7:0] LEN_CMD_OK = 8'h0C;
	localparam logic [7:0] LEN_CMD_NO = 8'h06;
	// Fixed response bytes for standard and VPD data, and serial text base in memory
	localparam logic [7:0] QUAL_ABSENT = 8'h7F;
	localparam logic [7:0] STD_VERSION = 8'h03;
	localparam logic [7:0] STD_FORMAT = 8'h02;
	localparam logic [7:0] STD_ADDL_LEN = 8'h9F;
	localparam logic [7:0] STD_FLAGS6 = 8'h01;
	localparam logic [7:0] STD_CLOCKING = 8'h0C;
	localparam logic [7:0] VPD00_LEN = 8'h02;
	localparam logic [7:0] VPD80_LEN = 8'h10;
	localparam logic [7:0] SERIAL_RAM_BASE = 8'hA0;
	// Byte 7: wb16 at bit 5; sync, linked, queuing set
	localparam logic [7:0] STD_FLAGS7 = 8'h1A;
	localparam int FLAG7_WB16 = 5;
	// Command support data
	localparam logic [2:0] SUP_NONE = 3'b001;
	localparam logic [2:0] SUP_STD = 3'b011;
	localparam logic [7:0] CDB6_SIZE = 8'h06;
	localparam logic [7:0] USE_SEL = 8'h03;
	localparam logic [7:0] USE_FULL = 8'hFF;
	// Status and sense
	localparam logic [7:0] ST_GOOD = 8'h00;
	localparam logic [7:0] ST_CHECK = 8'h02;
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
	localparam logic [7:0] ASC_BAD_LUN = 8'h25;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DECODE = 3'b001,
		S_FETCH = 3'b010,
		S_LOAD = 3'b011,
		S_HOLD = 3'b100,
		S_STATUS = 3'b101
	} state_t;

	typedef enum logic [2:0] {
		K_STD = 3'b000,
		K_VPD00 = 3'b001,
		K_VPD80 = 3'b010,
		K_VPD83 = 3'b011,
		K_CMD = 3'b100
	} kind_t;
endpackage

//--- rtl/text_mem_if.sv
// Link between the responder and its text memory.
// Assumes both ends share hclk.
interface text_mem_if;
	logic we;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [7:0] rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- rtl/text_mem.sv
// 256 x 8 text store for the ASCII identity fields.
// Assumes software loads it before the first command; contents are not reset.
module text_mem (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	text_mem_if.mem port // Write and read port
);
	logic [7:0] ram [256];
	logic [7:0] rdata_r;

	always_ff @(posedge hclk) begin
		if (port.we) begin
			ram[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= ram[port.raddr];
		end
	end

	assign port.rdata = rdata_r;
endmodule

//--- bench/initiator_model.sv
// Initiator side of the response byte link: takes each offered byte and keeps it.
// Assumes bytes are offered on hclk by a valid level that holds until taken.
module initiator_model (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic [7:0] din_byte, // Byte from target
	input wire logic din_valid, // Byte offered
	input wire logic slow, // Stall before each take
	input wire logic clr, // Forget taken bytes
	output logic din_ready = 1'b0, // Byte taken at this edge
	output logic [7:0] nbytes = 8'h00 // Bytes taken since clear
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [0:255];
	logic [1:0] wait_r = 2'h0;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			din_ready <= 1'b0;
			nbytes <= 8'h00;
			wait_r <= 2'h0;
		end else if (clr) begin
			din_ready <= 1'b0;
			nbytes <= 8'h00;
			wait_r <= 2'h0;
		end else if (din_valid && din_ready) begin
			got[nbytes] <= din_byte;
			nbytes <= nbytes + 8'h01;
			din_ready <= 1'b0;
			wait_r <= 2'h0;
		end else if (din_valid) begin
			// Slow mode waits four cycles before taking
			wait_r <= wait_r + 2'h1;
			din_ready <= !slow || wait_r == 2'h3;
		end
	end
endmodule

//--- bench/scsi_inquiry_responder_bench.sv
// Self-checking bench for the INQUIRY responder: AHB-Lite register access and
// command runs against the initiator model, compared byte by byte.
// Assumes zero wait states and the package register map.
module scsi_inquiry_responder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic slow = 1'b0;
	logic clr = 1'b0;
	logic hreadyout, hresp, din_valid, din_ready, status_valid, last_abs, last_w16;
	logic [31:0] hrdata, rd;
	logic [7:0] din_byte, status_byte, nbytes;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	localparam logic [7:0] CMD12 [12] = '{8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h06, 8'h12, 8'h03, 8'hFF, 8'h00,
		8'hFF, 8'h03};
	localparam logic [7:0] VP [3] = '{8'h00, 8'h80, 8'h83};
	localparam int VN [3] = '{6, 20, 4};
	localparam inquiry_pkg::kind_t VK [3] = '{inquiry_pkg::K_VPD00, inquiry_pkg::K_VPD80, inquiry_pkg::K_VPD83};
	localparam logic [7:0] EB1 [4] = '{8'h03, 8'h00, 8'h01, 8'h02};
	localparam logic [7:0] EPG [4] = '{8'h00, 8'h01, 8'h81, 8'hC0};
	always #12.5 hclk = ~hclk;
	scsi_inquiry_responder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .din_byte(din_byte), .din_valid(din_valid), .din_ready(din_ready),
		.status_valid(status_valid), .status_byte(status_byte));
	initiator_model u_init (.hclk(hclk), .hresetn(hresetn), .din_byte(din_byte), .din_valid(din_valid),
		.slow(slow), .clr(clr), .din_ready(din_ready), .nbytes(nbytes));
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("FAIL %0t run did not finish", $time);
			end_of_test();
		end
	end
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		checked++;
		if ((got & m) !== (exp & m)) begin
			errors++;
			$display("FAIL %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic wr_en, input logic [4:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {27'h0, a};
		hwrite <= wr_en;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	function automatic logic [7:0] txt(input logic [7:0] a);
		return a ^ 8'h55;
	endfunction
	function automatic logic [47:0] cdb6(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] pg,
		input logic [7:0] alen);
		return {8'h00, alen, 8'h00, pg, b1, op};
	endfunction
	function automatic logic [7:0] exp_byte(input inquiry_pkg::kind_t k, input logic [7:0] pg, input int i);
		logic [7:0] b;
		b = 8'h00;
		case (k)
			inquiry_pkg::K_STD: begin
				case (i)
					2: b = 8'h03;
					3: b = 8'h02;
					4: b = 8'h9F;
					6: b = 8'h01;
					7: b = {2'b00, last_w16, 5'b11010};
					53: b = 8'h0C;
					default: if ((i >= 8 && i <= 43) || (i >= 96 && i <= 145)) b = txt(i[7:0]);
				endcase
			end
			inquiry_pkg::K_VPD00: b = (i == 3) ? 8'h02 : (i == 4) ? 8'h80 : (i == 5) ? 8'h83 : 8'h00;
			inquiry_pkg::K_VPD80: b = (i == 1) ? 8'h80 : (i == 3) ? 8'h10 : (i >= 4) ? txt(8'hA0 + i[7:0]) : 8'h00;
			inquiry_pkg::K_VPD83: b = (i == 1) ? 8'h83 : 8'h00;
			default: b = (pg == 8'h12) ? CMD12[i] : (i == 1) ? 8'h01 : 8'h00;
		endcase
		if (i == 0) b = last_abs ? 8'h7F : 8'h00;
		return b;
	endfunction
	task automatic issue(input logic [47:0] c, input logic [3:0] ctl);
		last_abs = ctl[1];
		last_w16 = ctl[2];
		clr <= 1'b1;
		ahb(1'b1, inquiry_pkg::OFS_CDB_LO, c[31:0]);
		clr <= 1'b0;
		ahb(1'b1, inquiry_pkg::OFS_CDB_HI, {16'h0, c[47:32]});
		ahb(1'b1, inquiry_pkg::OFS_CTRL, {28'h0, ctl | 4'h1});
	endtask
	task automatic finish(input logic [7:0] st, input int n, input inquiry_pkg::kind_t k, input logic [7:0] pg,
		input int chk, input logic [7:0] asc);
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (status_valid !== 1'b1 && i < 4000);
		if (status_valid !== 1'b1) begin
			errors++;
			$display("FAIL %0t no status pulse", $time);
		end
		cmp8(status_byte, st);
		for (i = 0; i < n && i < chk; i++) cmp8(u_init.got[i], exp_byte(k, pg, i));
		cmp8(nbytes, n[7:0]);
		ahb(1'b0, inquiry_pkg::OFS_STATUS, 32'h0);
		cmp8({6'h00, hresp, hreadyout}, 8'h01);
		cmp32(rd, {n[7:0], asc, 4'h0, (st == inquiry_pkg::ST_CHECK) ? 4'h5 : 4'h0, 5'h0, st == inquiry_pkg::ST_CHECK,
			2'b10}, (st == inquiry_pkg::ST_CHECK) ? 32'hFFFFFFFF : 32'hFF000007);
	endtask
	initial begin
		int a;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, inquiry_pkg::OFS_STATUS, 32'h0);
		cmp32(rd, 32'h0, 32'h00000007);
		ahb(1'b1, 5'h14, 32'hFFFFFFFF);
		ahb(1'b0, 5'h14, 32'h0);
		cmp32(rd, 32'h0, 32'hFFFFFFFF);
		for (a = 0; a < 256; a++) ahb(1'b1, inquiry_pkg::OFS_TEXT, {16'h0, txt(a[7:0]), a[7:0]});
		ahb(1'b0, inquiry_pkg::OFS_TEXT, 32'h0);
		cmp32(rd, 32'h0, 32'hFFFFFFFF);
		// Full standard data to a slow initiator; a CDB write and a new start while busy must be ignored
		slow <= 1'b1;
		issue(cdb6(inquiry_pkg::OP_INQUIRY, 8'h00, 8'h00, 8'hFF), 4'hC);
		ahb(1'b1, inquiry_pkg::OFS_CDB_LO, 32'hFFFFFFFF);
		ahb(1'b1, inquiry_pkg::OFS_CTRL, 32'h0000000D);
		finish(inquiry_pkg::ST_GOOD, 164, inquiry_pkg::K_STD, 8'h00, 164, 8'h00);
		ahb(1'b0, inquiry_pkg::OFS_CTRL, 32'h0);
		cmp32(rd, 32'h0000000C, 32'h0000000F);
		ahb(1'b0, inquiry_pkg::OFS_CDB_LO, 32'h0);
		cmp32(rd, 32'h00000012, 32'hFFFFFFFF);
		slow <= 1'b0;
		issue(cdb6(inquiry_pkg::OP_INQUIRY, 8'h00, 8'h00, 8'h00), 4'h0);
		finish(inquiry_pkg::ST_GOOD, 0, inquiry_pkg::K_STD, 8'h00, 0, 8'h00);
		issue(cdb6(inquiry_pkg::OP_INQUIRY, 8'h00, 8'h00, 8'h08), 4'h2);
		finish(inquiry_pkg::ST_GOOD, 8, inquiry_pkg::K_STD, 8'h00, 8, 8'h00);
		for (a = 0; a < 3; a++) begin
			issue(cdb6(inquiry_pkg::OP_INQUIRY, 8'h01, VP[a], 8'hFF), 4'h0);
			finish(inquiry_pkg::ST_GOOD, VN[a], VK[a], VP[a], VN[a], 8'h00);
		end
		issue(cdb6(inquiry_pkg::OP_INQUIRY, 8'h02, 8'h12, 8'hFF), 4'h0);
		finish(inquiry_pkg::ST_GOOD, 12, inquiry_pkg::K_CMD, 8'h12, 12, 8'h00);
		issue(cdb6(inquiry_pkg::OP_INQUIRY, 8'h02, 8'h03, 8'hFF), 4'h0);
		finish(inquiry_pkg::ST_GOOD, 6, inquiry_pkg::K_CMD, 8'h03, 2, 8'h00);
		for (a = 0; a < 4; a++) begin
			issue(cdb6(inquiry_pkg::OP_INQUIRY, EB1[a], EPG[a], 8'hFF), 4'h0);
			finish(inquiry_pkg::ST_CHECK, 0, inquiry_pkg::K_STD, 8'h00, 0, 8'h24);
		end
		issue(cdb6(8'h00, 8'h00, 8'h00, 8'hFF), 4'h2);
		finish(inquiry_pkg::ST_CHECK, 0, inquiry_pkg::K_STD, 8'h00, 0, 8'h25);
		issue(cdb6(inquiry_pkg::OP_REQ_SENSE, 8'h00, 8'h00, 8'hFF), 4'h2);
		finish(inquiry_pkg::ST_GOOD, 0, inquiry_pkg::K_STD, 8'h00, 0, 8'h00);
		issue(cdb6(8'h00, 8'h00, 8'h00, 8'hFF), 4'h0);
		finish(inquiry_pkg::ST_GOOD, 0, inquiry_pkg::K_STD, 8'h00, 0, 8'h00);
		end_of_test();
	end
endmodule
